// file: video_pixel_output_port_map.svh
// Contract
// RQ1: mode 0,0 puts a six-line vertical sync, aligned to pixels, on the vertical pin.
// RQ2: vsync_polarity sets the active level of vertical sync and field active.
// RQ3: modes 1,0 and 0,1 put field active on the vertical pin during viewable lines.
// RQ4: mode 0,0 hsync edges come from hsync_begin_pos and hsync_end_pos, two-clock steps.
// RQ5: hsync_polarity sets the active level of horizontal sync and line active.
// RQ6: modes 1,0 and 0,1 put a programmable line active window on the horizontal pin.
// RQ7: pixel bus carries 8-bit, 16-bit, 10-bit or 20-bit formats; bit 0 is LSB.
// RQ8: pixel bits 1..0 and 11..10 may be general output bits 1..0 and 3..2.
// RQ9: almost full asserts when fill reaches the margin held in fifo_margin_level; the code asserts at fill of 32 minus that margin.
// RQ10: almost empty asserts when fill falls to the margin from fifo_margin_level.
// RQ11: fifo_flag_polarity sets the active level of all three FIFO flags.
// RQ12: mode 1,0 multifunction pin shows half full while fill is at least half.
// RQ13: mode 0,1 multifunction pin shows qualified pixel clock for qualified FIFO mode.
// RQ14: mode 0,0 multifunction pin carries the serial genlock stream.
// RQ15: the far side supplies the FIFO read clock; pixels and controls leave on it.
// RQ16: clock qualifier marks the half-rate data phase, level set by its polarity bit.
// RQ17: half line clock runs at half the line-locked clock rate.
// RQ18: line-locked clock pin carries the line-locked clock derived from the system clock.
// RQ19: horizontal positions count from line start in two line-clock units and compare.
// RQ20: FIFO flags come from read-side occupancy and drop once it moves back past.
`ifndef VIDEO_PIXEL_OUTPUT_PORT_MAP_SVH
`define VIDEO_PIXEL_OUTPUT_PORT_MAP_SVH

`define VPO_FIFO_AW        5
`define VPO_FIFO_DEPTH     6'h20
`define VPO_FIFO_HALF      6'h10
`define VPO_H_TOTAL        10'h1ad
`define VPO_V_TOTAL        10'h20d
`define VPO_VSYNC_LINES    10'h006
`define VPO_VACT_BEGIN     10'h015
`define VPO_VACT_END       10'h105
`define VPO_GENLOCK_BITS   5'h18
`define VPO_PH_LLC_WRITE   2'h0
`define VPO_PH_STEP        2'h3

`endif

// file: video_pixel_output_port_pkg.sv
package video_pixel_output_port_pkg;

  typedef enum logic [1:0] {
    MODE_SYNC      = 2'h0,
    MODE_QUALIFIED = 2'h1,
    MODE_FLAGS     = 2'h2,
    MODE_RESERVED  = 2'h3
  } out_mode_e;

  typedef enum logic [1:0] {
    FMT_8BIT  = 2'h0,
    FMT_16BIT = 2'h1,
    FMT_10BIT = 2'h2,
    FMT_20BIT = 2'h3
  } pix_fmt_e;

  typedef struct packed {
    logic [9:0] luma;
    logic [9:0] chroma;
    logic       valid;
  } pixel_in_s;

  typedef struct packed {
    logic [19:0] data;
    logic        vsync;
    logic        field_act;
    logic        hsync;
    logic        line_act;
    logic        genlock;
  } fifo_entry_s;

  typedef struct packed {
    out_mode_e   output_mode_select;
    pix_fmt_e    pixel_format;
    logic        vsync_polarity;
    logic        hsync_polarity;
    logic [9:0]  hsync_begin_pos;
    logic [9:0]  hsync_end_pos;
    logic [9:0]  line_active_begin;
    logic [9:0]  line_active_end;
    logic [4:0]  fifo_margin_level;
    logic        fifo_flag_polarity;
    logic        clock_qualifier_polarity;
    logic [1:0]  gpo_enable;
    logic [3:0]  general_output_bits;
  } port_cfg_s;

endpackage : video_pixel_output_port_pkg

// file: video_pixel_output_port.sv
`timescale 1ns/10ps
`include "video_pixel_output_port_map.svh"

module video_pixel_output_port (
  // system clock (twice the line-locked rate) and reset
  input  wire logic                                i_mclk,
  input  wire logic                                i_rst_b,
  // far-side FIFO read clock
  input  wire logic                                i_fifo_read_clock,
  // decoded pixels and genlock payload, system clock domain
  input  wire video_pixel_output_port_pkg::pixel_in_s i_pixel,
  input  wire logic [23:0]                         i_genlock_word,
  // static configuration, system clock domain
  input  wire video_pixel_output_port_pkg::port_cfg_s i_cfg,
  // pixel port, read clock domain
  output logic [19:0]                              o_pixel_bus,
  output logic                                     o_vertical_out,
  output logic                                     o_horizontal_out,
  output logic                                     o_multi_out,
  output logic                                     o_almost_full_flag,
  output logic                                     o_almost_empty_flag,
  // clock outputs, system clock domain
  output logic                                     o_line_locked_clock,
  output logic                                     o_half_line_clock,
  output logic                                     o_clock_qualifier_out
);

  localparam int AW = `VPO_FIFO_AW;

  function automatic logic [AW:0] bin2gray(input logic [AW:0] b);
    bin2gray = b ^ (b >> 1);
  endfunction : bin2gray

  function automatic logic [AW:0] gray2bin(input logic [AW:0] g);
    logic [AW:0] b;
    b = '0;
    for (int i = AW; i >= 0; i--) begin
      b[i] = (i == AW) ? g[i] : (b[i+1] ^ g[i]);
    end
    gray2bin = b;
  endfunction : gray2bin

  function automatic logic in_window(input logic [9:0] pos, input logic [9:0] lo,
                                     input logic [9:0] hi);
    in_window = (pos >= lo) && (pos < hi);
  endfunction : in_window

  // active-high level to pin level; a polarity bit of 1 means active high
  function automatic logic apply_pol(input logic level, input logic pol);
    apply_pol = level ~^ pol;
  endfunction : apply_pol

  // ---------------- system clock domain ----------------
  logic [1:0]  ph_q;
  logic        llc_q;
  logic        half_line_clock_q;
  logic        qual_q;
  logic [9:0]  hcnt_q;
  logic [9:0]  vcnt_q;
  logic [23:0] gl_sr_q;
  logic [4:0]  gl_cnt_q;

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ph_q <= 2'h0;
    end else begin
      ph_q <= ph_q + 2'h1;
    end
  end

  // clock outputs built from flops so they leave glitch free
  // RQ18 line clock out
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      llc_q <= 1'b0;
    end else begin
      llc_q <= ~ph_q[0];
    end
  end

  // RQ17 half rate clock
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      half_line_clock_q <= 1'b0;
    end else begin
      half_line_clock_q <= ~ph_q[1];
    end
  end

  // RQ16 qualifier with polarity
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      qual_q <= 1'b0;
    end else begin
      qual_q <= apply_pol(ph_q == `VPO_PH_STEP, i_cfg.clock_qualifier_polarity);
    end
  end

  assign o_line_locked_clock   = llc_q;
  assign o_half_line_clock     = half_line_clock_q;
  assign o_clock_qualifier_out = qual_q;

  logic hstep;
  logic line_end;
  assign hstep    = (ph_q == `VPO_PH_STEP);
  assign line_end = hstep && (hcnt_q == `VPO_H_TOTAL - 10'h1);

  // RQ19 line position counter
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      hcnt_q <= 10'h0;
      vcnt_q <= 10'h0;
    end else if (line_end) begin
      hcnt_q <= 10'h0;
      vcnt_q <= (vcnt_q == `VPO_V_TOTAL - 10'h1) ? 10'h0 : vcnt_q + 10'h1;
    end else if (hstep) begin
      hcnt_q <= hcnt_q + 10'h1;
    end
  end

  // RQ14 genlock serializer
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      gl_sr_q  <= 24'h0;
      gl_cnt_q <= 5'h0;
    end else if (line_end) begin
      gl_sr_q  <= i_genlock_word;
      gl_cnt_q <= `VPO_GENLOCK_BITS;
    end else if (hstep && gl_cnt_q != 5'h0) begin
      gl_sr_q  <= {gl_sr_q[22:0], 1'b0};
      gl_cnt_q <= gl_cnt_q - 5'h1;
    end
  end

  // write side of the output FIFO
  video_pixel_output_port_pkg::fifo_entry_s mem_q [0:(1<<AW)-1];
  video_pixel_output_port_pkg::fifo_entry_s wr_entry;
  logic [AW:0] wr_bin_q;
  logic [AW:0] wr_gray_q;
  logic [AW:0] rg_meta_q;
  logic [AW:0] rg_sync_q;
  // read pointers live in the read domain but the write side syncs their gray copy
  logic [AW:0] rd_bin_q;
  logic [AW:0] rd_gray_q;
  logic        wr_full;
  logic        wr_en;

  assign wr_full = (wr_bin_q - gray2bin(rg_sync_q)) == `VPO_FIFO_DEPTH;
  // one pixel per line-locked cycle; a full FIFO drops rather than stalls the decoder
  assign wr_en   = i_pixel.valid && ({1'b0, ph_q[0]} == `VPO_PH_LLC_WRITE) && !wr_full;

  always_comb begin
    wr_entry = '0;
    // RQ7 format packing
    case (i_cfg.pixel_format)
      video_pixel_output_port_pkg::FMT_8BIT:  wr_entry.data[19:12] = i_pixel.luma[9:2];
      video_pixel_output_port_pkg::FMT_16BIT: begin
        wr_entry.data[19:12] = i_pixel.luma[9:2];
        wr_entry.data[9:2]   = i_pixel.chroma[9:2];
      end
      video_pixel_output_port_pkg::FMT_10BIT: wr_entry.data[19:10] = i_pixel.luma;
      default:                                wr_entry.data = {i_pixel.luma, i_pixel.chroma};
    endcase
    // RQ1 six-line vertical sync
    wr_entry.vsync     = (vcnt_q < `VPO_VSYNC_LINES);
    // RQ3 viewable field window
    wr_entry.field_act = in_window(vcnt_q, `VPO_VACT_BEGIN, `VPO_VACT_END);
    // RQ4 programmable hsync edges
    wr_entry.hsync     = in_window(hcnt_q, i_cfg.hsync_begin_pos, i_cfg.hsync_end_pos);
    // RQ6 programmable line window
    wr_entry.line_act  = in_window(hcnt_q, i_cfg.line_active_begin, i_cfg.line_active_end);
    wr_entry.genlock   = gl_sr_q[23];
  end

  always_ff @(posedge i_mclk) begin
    if (wr_en) begin
      mem_q[wr_bin_q[AW-1:0]] <= wr_entry;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wr_bin_q  <= '0;
      wr_gray_q <= '0;
    end else if (wr_en) begin
      wr_bin_q  <= wr_bin_q + 6'h1;
      wr_gray_q <= bin2gray(wr_bin_q + 6'h1);
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rg_meta_q <= '0;
      rg_sync_q <= '0;
    end else begin
      rg_meta_q <= rd_gray_q;
      rg_sync_q <= rg_meta_q;
    end
  end

  // ---------------- read clock domain ----------------
  logic [AW:0] wg_meta_q;
  logic [AW:0] wg_sync_q;
  video_pixel_output_port_pkg::port_cfg_s cfg_meta_q;
  video_pixel_output_port_pkg::port_cfg_s cfg_q;
  logic [AW:0] occ;
  logic        rd_en;
  logic [19:0] bus_d;
  video_pixel_output_port_pkg::fifo_entry_s rd_entry;

  // RQ15 read clock crossing
  always_ff @(posedge i_fifo_read_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wg_meta_q  <= '0;
      wg_sync_q  <= '0;
      cfg_meta_q <= '0;
      cfg_q      <= '0;
    end else begin
      wg_meta_q  <= wr_gray_q;
      wg_sync_q  <= wg_meta_q;
      // configuration is quasi-static; a two-flop sync per bit is enough
      cfg_meta_q <= i_cfg;
      cfg_q      <= cfg_meta_q;
    end
  end

  assign occ      = gray2bin(wg_sync_q) - rd_bin_q;
  assign rd_en    = (occ != 6'h0);
  assign rd_entry = mem_q[rd_bin_q[AW-1:0]];

  always_ff @(posedge i_fifo_read_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rd_bin_q  <= '0;
      rd_gray_q <= '0;
    end else if (rd_en) begin
      rd_bin_q  <= rd_bin_q + 6'h1;
      rd_gray_q <= bin2gray(rd_bin_q + 6'h1);
    end
  end

  always_comb begin
    bus_d = rd_entry.data;
    // RQ8 general output overrides
    if (cfg_q.gpo_enable[0]) begin
      bus_d[1:0] = cfg_q.general_output_bits[1:0];
    end
    if (cfg_q.gpo_enable[1]) begin
      bus_d[11:10] = cfg_q.general_output_bits[3:2];
    end
  end

  // RQ15 data leaves on read clock
  always_ff @(posedge i_fifo_read_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_pixel_bus <= 20'h0;
    end else if (rd_en) begin
      o_pixel_bus <= bus_d;
    end
  end

  // RQ2 vertical polarity
  always_ff @(posedge i_fifo_read_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_vertical_out <= 1'b0;
    end else if (rd_en) begin
      if (cfg_q.output_mode_select == video_pixel_output_port_pkg::MODE_SYNC) begin
        o_vertical_out <= apply_pol(rd_entry.vsync, cfg_q.vsync_polarity);
      end else begin
        o_vertical_out <= apply_pol(rd_entry.field_act, cfg_q.vsync_polarity);
      end
    end
  end

  // RQ5 horizontal polarity
  always_ff @(posedge i_fifo_read_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_horizontal_out <= 1'b0;
    end else if (rd_en) begin
      if (cfg_q.output_mode_select == video_pixel_output_port_pkg::MODE_SYNC) begin
        o_horizontal_out <= apply_pol(rd_entry.hsync, cfg_q.hsync_polarity);
      end else begin
        o_horizontal_out <= apply_pol(rd_entry.line_act, cfg_q.hsync_polarity);
      end
    end
  end

  logic half_full;
  logic genlock_q;
  assign half_full = (occ >= `VPO_FIFO_HALF);

  always_ff @(posedge i_fifo_read_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      genlock_q <= 1'b0;
    end else if (rd_en) begin
      genlock_q <= rd_entry.genlock;
    end
  end

  // RQ20 flags from read-side fill
  // RQ9 almost full margin
  always_ff @(posedge i_fifo_read_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_almost_full_flag <= 1'b0;
    end else begin
      o_almost_full_flag <= apply_pol(occ >= `VPO_FIFO_DEPTH - {1'b0, cfg_q.fifo_margin_level},
                                      cfg_q.fifo_flag_polarity);
    end
  end

  // RQ10 almost empty margin
  always_ff @(posedge i_fifo_read_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_almost_empty_flag <= 1'b0;
    end else begin
      o_almost_empty_flag <= apply_pol(occ <= {1'b0, cfg_q.fifo_margin_level},
                                       cfg_q.fifo_flag_polarity);
    end
  end

  // multifunction pin by output mode
  always_ff @(posedge i_fifo_read_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_multi_out <= 1'b0;
    end else begin
      case (cfg_q.output_mode_select)
        // RQ14 genlock on multifunction pin
        video_pixel_output_port_pkg::MODE_SYNC:      o_multi_out <= rd_en ? rd_entry.genlock
                                                                          : genlock_q;
        // RQ13 qualified pixel clock
        video_pixel_output_port_pkg::MODE_QUALIFIED: o_multi_out <= rd_en;
        // RQ12 half full, RQ11 polarity
        default: o_multi_out <= apply_pol(half_full, cfg_q.fifo_flag_polarity);
      endcase
    end
  end

endmodule : video_pixel_output_port

// file: vpo_monitor.sv
`timescale 1ns/10ps
module vpo_monitor (
  // clocks, reset and configuration
  input wire logic                                   i_mclk,
  input wire logic                                   i_rst_b,
  input wire logic                                   i_fifo_read_clock,
  input wire video_pixel_output_port_pkg::port_cfg_s i_cfg,
  // outputs watched
  input wire logic [19:0]                            o_pixel_bus,
  input wire logic                                   o_multi_out,
  input wire logic                                   o_almost_full_flag,
  input wire logic                                   o_almost_empty_flag,
  input wire logic                                   o_line_locked_clock,
  input wire logic                                   o_half_line_clock,
  input wire logic                                   o_clock_qualifier_out
);
  logic [3:0]                             age_q;
  video_pixel_output_port_pkg::port_cfg_s cfg_q;
  logic ok, fp, af_on, ae_on, hf_on, mf, low_margin, qp;
  // config crosses through synchronisers, so relations wait until it has settled
  always_ff @(posedge i_fifo_read_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cfg_q <= '0;
      age_q <= 4'h0;
    end else begin
      cfg_q <= i_cfg;
      age_q <= (cfg_q != i_cfg) ? 4'h0 : age_q + 4'(age_q != 4'hf);
    end
  end
  assign ok    = age_q == 4'hf;
  assign fp    = i_cfg.fifo_flag_polarity;
  assign qp    = i_cfg.clock_qualifier_polarity;
  assign af_on = o_almost_full_flag == fp;
  assign ae_on = o_almost_empty_flag == fp;
  assign hf_on = o_multi_out == fp;
  assign mf    = ok && i_cfg.output_mode_select[1];
  assign low_margin = i_cfg.fifo_margin_level < 5'h10;
  chk_full_half: assert property (
    @(posedge i_fifo_read_clock) disable iff (!i_rst_b) mf && low_margin && af_on |-> hf_on)
    else $error("half full flag missing while almost full");
  chk_empty_low: assert property (
    @(posedge i_fifo_read_clock) disable iff (!i_rst_b) mf && low_margin && ae_on |-> !hf_on)
    else $error("half full flag set while almost empty");
  chk_flags_apart: assert property (
    @(posedge i_fifo_read_clock) disable iff (!i_rst_b) ok && low_margin |-> !(af_on && ae_on))
    else $error("almost full and almost empty together");
  chk_gpo_bits: assert property (
    @(posedge i_fifo_read_clock) disable iff (!i_rst_b)
    ok && i_cfg.gpo_enable[0] && $changed(o_pixel_bus)
    |-> o_pixel_bus[1:0] == i_cfg.general_output_bits[1:0])
    else $error("general output bits wrong");
  chk_qual_pop: assert property (
    @(posedge i_fifo_read_clock) disable iff (!i_rst_b)
    ok && i_cfg.output_mode_select == video_pixel_output_port_pkg::MODE_QUALIFIED
    && $changed(o_pixel_bus) |-> o_multi_out)
    else $error("qualified clock missing at pop");
  chk_llc_toggle: assert property (
    @(posedge i_mclk) disable iff (!i_rst_b) 1'b1 |=> $changed(o_line_locked_clock))
    else $error("line clock not toggling");
  chk_half_rate: assert property (
    @(posedge i_mclk) disable iff (!i_rst_b) $rose(o_half_line_clock)
    |=> o_half_line_clock ##1 !o_half_line_clock [*2] ##1 o_half_line_clock)
    else $error("half line clock period wrong");
  chk_qual_gap: assert property (
    @(posedge i_mclk) disable iff (!i_rst_b)
    $past(i_rst_b, 4) && $changed(o_clock_qualifier_out) && o_clock_qualifier_out == qp
    |=> (o_clock_qualifier_out != qp) [*3] ##1 o_clock_qualifier_out == qp)
    else $error("clock qualifier spacing wrong");
  cover property (@(posedge i_fifo_read_clock) mf && af_on && hf_on);
  cover property (@(posedge i_fifo_read_clock) mf && ae_on);
  cover property (@(posedge i_fifo_read_clock) ok && o_multi_out && !i_cfg.output_mode_select[1]);
endmodule : vpo_monitor

// file: video_capture_model.sv
`timescale 1ns/10ps
module video_capture_model (
  // pacing
  input  wire logic        i_slow,
  // pixel port
  input  wire logic [19:0] i_pixel_bus,
  output logic             o_fifo_read_clock,
  output logic [19:0]      o_word
);
  initial begin
    o_fifo_read_clock = 1'b0;
    #7;
    forever #(i_slow ? 128 : 32) o_fifo_read_clock = ~o_fifo_read_clock;
  end
  always_ff @(posedge o_fifo_read_clock) begin
    o_word <= i_pixel_bus;
  end
endmodule : video_capture_model

// file: tb_top.sv
`timescale 1ns/10ps
module tb_top;
  logic                                   i_mclk;
  logic                                   i_rst_b;
  logic                                   i_fifo_read_clock;
  logic                                   slow;
  logic                                   psel;
  logic                                   pin;
  logic [23:0]                            i_genlock_word;
  logic [19:0]                            o_pixel_bus;
  logic [19:0]                            word;
  logic o_vertical_out, o_horizontal_out, o_multi_out, o_almost_full_flag, o_almost_empty_flag;
  logic o_line_locked_clock, o_half_line_clock, o_clock_qualifier_out;
  video_pixel_output_port_pkg::pixel_in_s i_pixel;
  video_pixel_output_port_pkg::port_cfg_s i_cfg;
  realtime                                t_end;
  int                                     errors;
  int                                     checks;

  video_pixel_output_port dut (.i_mclk, .i_rst_b, .i_fifo_read_clock, .i_pixel, .i_genlock_word,
    .i_cfg, .o_pixel_bus, .o_vertical_out, .o_horizontal_out, .o_multi_out, .o_almost_full_flag,
    .o_almost_empty_flag, .o_line_locked_clock, .o_half_line_clock, .o_clock_qualifier_out);
  video_capture_model partner (.i_slow(slow), .i_pixel_bus(o_pixel_bus),
    .o_fifo_read_clock(i_fifo_read_clock), .o_word(word));

  assign pin = psel ? o_vertical_out : o_horizontal_out;
  initial i_mclk = 1'b0;
  always #25 i_mclk = ~i_mclk;

  task automatic cmp(input logic [19:0] got, input logic [19:0] exp, input string m);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask : cmp

  // pin follows pops, so edges jitter by a read clock or two
  task automatic width(input logic lvl, output realtime w);
    realtime t;
    wait (pin !== lvl);
    wait (pin === lvl);
    t = $realtime;
    wait (pin !== lvl);
    w = $realtime - t;
  endtask : width

  task automatic settle(input int ns);
    #(ns);
    @(negedge i_mclk);
  endtask : settle

  task automatic vsync_check;
    realtime w;
    psel = 1'b1;
    width(1'b1, w);
    t_end = $realtime;
    cmp(20'(w > 514400 && w < 515200), 20'h1, "vsync width");
    settle(100);
    i_cfg.vsync_polarity = 1'b0;
    settle(5000);
    cmp(20'(o_vertical_out), 20'h1, "vsync polarity");
  endtask : vsync_check

  task automatic hsync_check;
    realtime w;
    psel = 1'b0;
    // genlock steps 15..19 carry ones, steps 24 on carry zeros
    wait (pin === 1'b0);
    wait (pin === 1'b1);
    #1400;
    cmp(20'(o_multi_out), 20'h1, "genlock ones");
    #2000;
    cmp(20'(o_multi_out), 20'h0, "genlock tail");
    width(1'b1, w);
    cmp(20'(w > 3800 && w < 4200), 20'h1, "hsync high width");
    settle(100);
    i_cfg.hsync_polarity = 1'b0;
    width(1'b0, w);
    cmp(20'(w > 3800 && w < 4200), 20'h1, "hsync low width");
  endtask : hsync_check

  task automatic field_check;
    i_cfg.output_mode_select = video_pixel_output_port_pkg::MODE_FLAGS;
    settle(5000);
    cmp(20'(o_vertical_out), 20'h1, "field active early");
    #(t_end + 1372800.0 - $realtime);
    cmp(20'(o_vertical_out), 20'h0, "field active missing");
  endtask : field_check

  task automatic flag_check;
    slow = 1'b1;
    settle(60000);
    cmp(20'({o_almost_full_flag, o_almost_empty_flag, o_multi_out}), 20'h5, "full");
    slow = 1'b0;
    i_pixel.valid = 1'b0;
    settle(10000);
    cmp(20'({o_almost_full_flag, o_almost_empty_flag, o_multi_out}), 20'h2, "empty");
    i_cfg.fifo_flag_polarity = 1'b0;
    settle(3000);
    cmp(20'({o_almost_full_flag, o_almost_empty_flag, o_multi_out}), 20'h5, "low");
  endtask : flag_check

  task automatic format_check;
    logic [19:0] m;
    logic [19:0] e;
    i_pixel.valid = 1'b1;
    i_cfg.output_mode_select = video_pixel_output_port_pkg::MODE_QUALIFIED;
    for (int f = 0; f < 4; f++) begin
      i_cfg.pixel_format = video_pixel_output_port_pkg::pix_fmt_e'(f);
      i_cfg.gpo_enable = (f == 3) ? 2'h3 : 2'h0;
      settle(5000);
      case (f)
        0: begin m = 20'hff000; e = 20'ha9000; end
        1: begin m = 20'hff3fc; e = 20'ha91c8; end
        2: begin m = 20'hffc00; e = 20'ha9400; end
        default: begin m = 20'hfffff; e = 20'ha99ca; end
      endcase
      cmp(word & m, e, "pixel format");
    end
  endtask : format_check

  task automatic end_of_test;
    if (errors == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_of_test

  initial begin
    errors = 0;
    checks = 0;
    i_rst_b = 1'b0;
    slow = 1'b0;
    psel = 1'b1;
    i_genlock_word = 24'hc3a5f0;
    i_pixel = '{luma: 10'h2a5, chroma: 10'h1cb, valid: 1'b1};
    i_cfg = '0;
    i_cfg.pixel_format = video_pixel_output_port_pkg::FMT_20BIT;
    i_cfg.vsync_polarity = 1'b1;
    i_cfg.hsync_polarity = 1'b1;
    i_cfg.hsync_begin_pos = 10'h00a;
    i_cfg.hsync_end_pos = 10'h01e;
    i_cfg.line_active_end = 10'h100;
    i_cfg.fifo_margin_level = 5'h08;
    i_cfg.fifo_flag_polarity = 1'b1;
    i_cfg.clock_qualifier_polarity = 1'b1;
    i_cfg.general_output_bits = 4'ha;
    repeat (16) @(negedge i_mclk);
    i_rst_b = 1'b1;
    vsync_check();
    hsync_check();
    field_check();
    flag_check();
    format_check();
    end_of_test();
  end

  initial begin
    #3000000;
    errors++;
    end_of_test();
  end
endmodule : tb_top

bind video_pixel_output_port vpo_monitor chk (.i_mclk, .i_rst_b, .i_fifo_read_clock, .i_cfg,
  .o_pixel_bus, .o_multi_out, .o_almost_full_flag, .o_almost_empty_flag, .o_line_locked_clock,
  .o_half_line_clock, .o_clock_qualifier_out);
